// ### common/sdbp_cfg.svh
// offsets, field positions and fixed values of the serial dma buffer pointers
// assumes a 16-bit register port addressed at the printed byte offsets
`ifndef SDBP_CFG_SVH
`define SDBP_CFG_SVH
`define SDBP_OFF_RX_A_START 16'h4480
`define SDBP_OFF_RX_A_END   16'h4482
`define SDBP_OFF_RX_B_START 16'h4484
`define SDBP_OFF_RX_B_END   16'h4486
`define SDBP_OFF_TX_A_START 16'h4488
`define SDBP_OFF_TX_A_END   16'h448A
`define SDBP_OFF_TX_B_START 16'h448C
`define SDBP_OFF_TX_B_END   16'h448E
`define SDBP_OFF_RX_A_NEXT  16'h4490
`define SDBP_OFF_RX_B_NEXT  16'h4492
`define SDBP_OFF_TX_ACTIVE  16'h4494
`define SDBP_OFF_RX_A_ERR   16'h449A
`define SDBP_OFF_RX_B_ERR   16'h449C
`define SDBP_OFF_CONTROL    16'h44A0
`define SDBP_OFF_STATUS     16'h44A2
// buffer address registers share one 16-byte window
`define SDBP_BUF_WIN        12'h448
// fixed top bits of every start or end register, then of every offset register
`define SDBP_ADDR_TOP       3'h3
`define SDBP_CNT_TOP        3'h0
// control bits: [3:0] load rx a, rx b, tx a, tx b
`define SDBP_CTL_RX_RESET   4
`define SDBP_CTL_TX_RESET   5
// buffer indices
`define SDBP_RX_A           0
`define SDBP_RX_B           1
`define SDBP_TX_A           2
`define SDBP_TX_B           3
`endif

// ### common/sdbp_pkg.sv
// types shared by the serial dma buffer pointer block
// assumes sdbp_cfg.svh for all numeric constants
package sdbp_pkg;
   // one request to on-chip ram
   typedef struct packed {
      logic        valid;
      logic        we;
      logic [12:0] addr;
      logic [7:0]  data;
   } sdbp_mem_req_type;
   // one byte from the serial receive fifo
   typedef struct packed {
      logic [7:0] data;
      logic       frame_err;
   } sdbp_rx_byte_type;
   // transmit fetch sequence
   typedef enum logic [1:0] {
      SDBP_TX_IDLE   = 2'b00,
      SDBP_TX_ISSUED = 2'b01,
      SDBP_TX_CATCH  = 2'b11
   } sdbp_tx_state_type;
   // whole state of the block
   typedef struct packed {
      logic [3:0][12:0]  start;
      logic [3:0][12:0]  last;
      logic [3:0]        loaded;
      logic [1:0][12:0]  rx_cnt;
      logic [12:0]       tx_cnt;
      logic              rx_sel;
      logic              tx_sel;
      logic [1:0][12:0]  err_off;
      logic [1:0]        err_seen;
      logic [1:0]        frm;
      sdbp_tx_state_type tx_state;
      logic [1:0]        q_v;
      logic [1:0][7:0]   q_d;
      sdbp_mem_req_type  mem_req;
      logic [15:0]       rd_data;
      logic              rx_ready;
   } sdbp_state_type;
endpackage : sdbp_pkg

// ### src/sdbp_top.sv
// buffer pointers, offset counters and first-error capture of the serial dma
// assumes a ram that accepts every request and returns read data one cycle later
`timescale 1ns/1ps
`include "sdbp_cfg.svh"
module sdbp_top
   import sdbp_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rstn,
   // register port
   input  wire logic [15:0]       reg_addr,
   input  wire logic [15:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [15:0]       reg_rdata,
   // receive byte stream from serial fifo
   input  wire logic              rx_in_valid,
   input  wire sdbp_rx_byte_type  rx_in,
   output logic                   rx_in_ready,
   // transmit byte stream to serial fifo
   output logic                   tx_out_valid,
   output logic      [7:0]        tx_out_data,
   input  wire logic              tx_out_ready,
   // on-chip ram
   output sdbp_mem_req_type       mem_req,
   input  wire logic [7:0]        mem_rdata
);

   sdbp_state_type st_reg;
   sdbp_state_type st_next;
   logic           rx_take;
   logic           tx_issue;
   logic           rx_idx;
   logic [1:0]     tx_idx;

   // buffer register window decode: {hit, index, is end}
   function automatic logic [3:0] sdbp_slot(input logic [15:0] a);
      logic hit;
      hit = (a[15:4] == `SDBP_BUF_WIN) && !a[0];
      return {hit, a[3:2], a[1]};
   endfunction : sdbp_slot

   // handshakes and the buffer currently in use on each side
   assign rx_take  = rx_in_valid && st_reg.rx_ready;
   assign rx_idx   = st_reg.rx_sel;
   assign tx_idx   = st_reg.tx_sel ? 2'(`SDBP_TX_B) : 2'(`SDBP_TX_A);
   assign tx_issue = (st_reg.tx_state == SDBP_TX_IDLE) && st_reg.loaded[tx_idx]
                     && !st_reg.q_v[1] && !rx_take;

   // next state of the whole block
   always_comb begin
      logic [3:0]  ws;
      logic [3:0]  rs;
      logic [12:0] at;
      logic        pop;
      ws  = sdbp_slot(reg_addr);
      rs  = ws;
      at  = 13'h0;
      pop = tx_out_ready && st_reg.q_v[0];
      st_next = st_reg;
      st_next.mem_req = '0;
      st_next.rd_data = 16'h0;

      // software writes of buffer start and end addresses
      if (reg_wr && ws[3]) begin
         if (ws[0]) begin
            st_next.last[ws[2:1]] = reg_wdata[12:0];
         end else begin
            st_next.start[ws[2:1]] = reg_wdata[12:0];
         end
      end

      // receive byte goes to start plus offset of the active buffer
      if (rx_take) begin
         at = 13'(st_reg.start[rx_idx] + st_reg.rx_cnt[rx_idx]);
         st_next.mem_req = '{valid: 1'b1, we: 1'b1, addr: at, data: rx_in.data};
         if (rx_in.frame_err) begin
            st_next.frm[rx_idx] = 1'b1;
            if (!st_reg.err_seen[rx_idx]) begin
               st_next.err_off[rx_idx]  = st_reg.rx_cnt[rx_idx];
               st_next.err_seen[rx_idx] = 1'b1;
            end
         end
         if (at == st_reg.last[rx_idx]) begin
            st_next.rx_cnt[rx_idx] = 13'h0;
            st_next.loaded[rx_idx] = 1'b0;
            st_next.rx_sel         = !st_reg.rx_sel;
         end else begin
            st_next.rx_cnt[rx_idx] = 13'(st_reg.rx_cnt[rx_idx] + 13'h1);
         end
      end

      // transmit fetch: issue, ram answers, catch into the queue
      case (st_reg.tx_state)
         SDBP_TX_IDLE: begin
            if (tx_issue) begin
               at = 13'(st_reg.start[tx_idx] + st_reg.tx_cnt);
               st_next.mem_req  = '{valid: 1'b1, we: 1'b0, addr: at, data: 8'h00};
               st_next.tx_state = SDBP_TX_ISSUED;
               if (at == st_reg.last[tx_idx]) begin
                  st_next.tx_cnt         = 13'h0;
                  st_next.loaded[tx_idx] = 1'b0;
                  st_next.tx_sel         = !st_reg.tx_sel;
               end else begin
                  st_next.tx_cnt = 13'(st_reg.tx_cnt + 13'h1);
               end
            end
         end
         SDBP_TX_ISSUED: begin
            st_next.tx_state = SDBP_TX_CATCH;
         end
         SDBP_TX_CATCH: begin
            st_next.tx_state = SDBP_TX_IDLE;
         end
         default: begin
            st_next.tx_state = SDBP_TX_IDLE;
         end
      endcase

      // two-entry queue toward the serial fifo, head always in entry 0
      if (pop) begin
         st_next.q_v[0] = st_reg.q_v[1];
         st_next.q_d[0] = st_reg.q_d[1];
         st_next.q_v[1] = 1'b0;
      end
      if (st_reg.tx_state == SDBP_TX_CATCH) begin
         if (!st_next.q_v[0]) begin
            st_next.q_v[0] = 1'b1;
            st_next.q_d[0] = mem_rdata;
         end else begin
            st_next.q_v[1] = 1'b1;
            st_next.q_d[1] = mem_rdata;
         end
      end

      // control: load a buffer that is not loaded, reset either direction
      if (reg_wr && reg_addr == `SDBP_OFF_CONTROL) begin
         for (int i = 0; i < 4; i++) begin
            if (reg_wdata[i] && !st_reg.loaded[i]) begin
               st_next.loaded[i] = 1'b1;
               if (i < 2) begin
                  st_next.err_seen[i[0]] = 1'b0;
                  st_next.err_off[i[0]]  = 13'h0;
                  st_next.frm[i[0]]      = 1'b0;
               end
            end
         end
         if (reg_wdata[`SDBP_CTL_RX_RESET]) begin
            st_next.loaded[1:0] = 2'b00;
            st_next.rx_cnt      = '0;
            st_next.rx_sel      = 1'b0;
            st_next.err_seen    = 2'b00;
            st_next.err_off     = '0;
            st_next.frm         = 2'b00;
         end
         if (reg_wdata[`SDBP_CTL_TX_RESET]) begin
            st_next.loaded[3:2] = 2'b00;
            st_next.tx_cnt      = 13'h0;
            st_next.tx_sel      = 1'b0;
            st_next.q_v         = 2'b00;
            st_next.tx_state    = SDBP_TX_IDLE;
         end
      end

      // receive side ready whenever the selected buffer stays loaded
      st_next.rx_ready = st_next.loaded[st_next.rx_sel];

      // register read, answered in the next cycle
      if (reg_rd) begin
         if (rs[3]) begin
            st_next.rd_data = {`SDBP_ADDR_TOP, rs[0] ? st_reg.last[rs[2:1]]
                                                     : st_reg.start[rs[2:1]]};
         end else begin
            case (reg_addr)
               `SDBP_OFF_RX_A_NEXT: st_next.rd_data = {`SDBP_CNT_TOP, st_reg.rx_cnt[0]};
               `SDBP_OFF_RX_B_NEXT: st_next.rd_data = {`SDBP_CNT_TOP, st_reg.rx_cnt[1]};
               `SDBP_OFF_TX_ACTIVE: st_next.rd_data = {`SDBP_CNT_TOP, st_reg.tx_cnt};
               `SDBP_OFF_RX_A_ERR:  st_next.rd_data = {`SDBP_CNT_TOP, st_reg.err_off[0]};
               `SDBP_OFF_RX_B_ERR:  st_next.rd_data = {`SDBP_CNT_TOP, st_reg.err_off[1]};
               `SDBP_OFF_STATUS: begin
                  st_next.rd_data = {8'h00, st_reg.frm, st_reg.tx_sel, st_reg.rx_sel,
                                     st_reg.loaded};
               end
               default: st_next.rd_data = 16'h0000;
            endcase
         end
      end
   end

   // state register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_reg          <= '0;
         st_reg.tx_state <= SDBP_TX_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs straight from the state register
   assign reg_rdata    = st_reg.rd_data;
   assign rx_in_ready  = st_reg.rx_ready;
   assign tx_out_valid = st_reg.q_v[0];
   assign tx_out_data  = st_reg.q_d[0];
   assign mem_req      = st_reg.mem_req;

   // helper: software load or receive reset of a receive buffer
   logic [1:0] rx_rearm;
   assign rx_rearm[0] = reg_wr && reg_addr == `SDBP_OFF_CONTROL
                        && (reg_wdata[`SDBP_RX_A] || reg_wdata[`SDBP_CTL_RX_RESET]);
   assign rx_rearm[1] = reg_wr && reg_addr == `SDBP_OFF_CONTROL
                        && (reg_wdata[`SDBP_RX_B] || reg_wdata[`SDBP_CTL_RX_RESET]);

   // helper: software reset of either direction
   logic       rx_reset_wr;
   logic       tx_reset_wr;
   assign rx_reset_wr = reg_wr && reg_addr == `SDBP_OFF_CONTROL
                        && reg_wdata[`SDBP_CTL_RX_RESET];
   assign tx_reset_wr = reg_wr && reg_addr == `SDBP_OFF_CONTROL
                        && reg_wdata[`SDBP_CTL_TX_RESET];

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   // transmit fetch steps
   sequence s_tx_req;
      mem_req.valid && !mem_req.we && st_reg.tx_state == SDBP_TX_ISSUED;
   endsequence
   sequence s_tx_catch;
      st_reg.tx_state == SDBP_TX_CATCH ##1 st_reg.q_v[0];
   endsequence

   a_tx_fetch_seq: assert property (tx_issue |=> s_tx_req ##1 s_tx_catch)
      else $error("transmit fetch did not complete in three cycles");

   a_tx_wrap_zero: assert property (tx_issue && 13'(st_reg.start[tx_idx] + st_reg.tx_cnt)
      == st_reg.last[tx_idx] |=> st_reg.tx_cnt == 13'h0 && !st_reg.loaded[$past(tx_idx)])
      else $error("transmit offset did not wrap at buffer end");

   a_tx_cnt_step: assert property (tx_issue && 13'(st_reg.start[tx_idx] + st_reg.tx_cnt)
      != st_reg.last[tx_idx] && !tx_reset_wr
      |=> st_reg.tx_cnt == 13'($past(st_reg.tx_cnt) + 13'h1))
      else $error("transmit offset did not advance by one");

   a_rx_place_a: assert property (rx_take && !st_reg.rx_sel |=> mem_req.we
      && mem_req.addr == 13'($past(st_reg.start[0]) + $past(st_reg.rx_cnt[0])))
      else $error("receive byte placed outside buffer a");

   a_rx_wrap_next: assert property (rx_take && 13'(st_reg.start[rx_idx]
      + st_reg.rx_cnt[rx_idx]) == st_reg.last[rx_idx]
      |=> st_reg.rx_cnt[$past(rx_idx)] == 13'h0)
      else $error("receive offset did not wrap at buffer end");

   a_err_first_a: assert property (rx_take && !rx_idx && rx_in.frame_err
      && !st_reg.err_seen[0] && !rx_rearm[0]
      |=> st_reg.err_off[0] == $past(st_reg.rx_cnt[0]))
      else $error("first error offset of buffer a not captured");

   a_err_first_b: assert property (rx_take && rx_idx && rx_in.frame_err
      && !st_reg.err_seen[1] && !rx_rearm[1]
      |=> st_reg.err_off[1] == $past(st_reg.rx_cnt[1]))
      else $error("first error offset of buffer b not captured");

   a_err_zero_idle: assert property (!st_reg.err_seen[0] |-> st_reg.err_off[0] == 13'h0)
      else $error("error offset nonzero without an error");

   a_err_hold_val: assert property (st_reg.err_seen[1] && !rx_rearm[1]
      |=> $stable(st_reg.err_off[1]))
      else $error("captured error offset changed");

   a_err_rearm_ld: assert property (rx_rearm[0] && !st_reg.loaded[0]
      |=> !st_reg.err_seen[0] && !st_reg.frm[0]
      ##1 st_reg.err_off[0] == 13'h0 || st_reg.err_seen[0])
      else $error("error capture not re-armed on reload");

   a_frm_flag_set: assert property (rx_take && rx_in.frame_err && !rx_rearm[rx_idx]
      |=> st_reg.frm[$past(rx_idx)])
      else $error("frame error flag not set");

   a_cfg_b_write: assert property (reg_wr && reg_addr == `SDBP_OFF_RX_B_START
      |=> st_reg.start[1] == $past(reg_wdata[12:0]) && $stable(st_reg.start[0]))
      else $error("receive buffer b start not written independently");

   a_cfg_tx_b: assert property (reg_wr && reg_addr == `SDBP_OFF_TX_B_END
      |=> st_reg.last[3] == $past(reg_wdata[12:0]) && $stable(st_reg.last[2]))
      else $error("transmit buffer b end not written independently");

   a_rd_fixed_top: assert property (reg_rd && sdbp_slot(reg_addr) >= 4'h8
      |=> reg_rdata[15:13] == 3'b011)
      else $error("fixed top bits of address register wrong");

   // receive placement, counting and capture
   a_rx_place_b: assert property (rx_take && st_reg.rx_sel |=> mem_req.we
      && mem_req.addr == 13'($past(st_reg.start[1]) + $past(st_reg.rx_cnt[1])))
      else $error("receive byte placed outside buffer b");

   a_rx_take_ld: assert property (rx_take |-> st_reg.loaded[rx_idx])
      else $error("receive byte taken into an unloaded buffer");

   a_rx_ready_out: assert property (rx_in_ready == st_reg.loaded[st_reg.rx_sel])
      else $error("receive ready disagrees with the selected buffer");

   // a taken byte becomes one ram write in the next cycle
   sequence s_rx_write;
      mem_req.valid && mem_req.we && mem_req.data == $past(rx_in.data);
   endsequence

   a_rx_write_step: assert property (rx_take |=> s_rx_write)
      else $error("taken receive byte not written to ram");

   a_rx_cnt_step: assert property (rx_take && !rx_reset_wr
      && 13'(st_reg.start[rx_idx] + st_reg.rx_cnt[rx_idx]) != st_reg.last[rx_idx]
      |=> st_reg.rx_cnt[$past(rx_idx)] == 13'($past(st_reg.rx_cnt[rx_idx]) + 13'h1))
      else $error("receive offset did not advance by one");

   a_err_hold_a: assert property (st_reg.err_seen[0] && !rx_rearm[0]
      |=> $stable(st_reg.err_off[0]))
      else $error("captured error offset of buffer a changed");

   a_err_zero_b: assert property (!st_reg.err_seen[1] |-> st_reg.err_off[1] == 13'h0)
      else $error("error offset of buffer b nonzero without an error");

   a_rx_reset_clr: assert property (rx_reset_wr
      |=> st_reg.frm == 2'b00 && st_reg.err_seen == 2'b00 && st_reg.rx_cnt == '0)
      else $error("receive reset left flags or offsets set");

   // transmit addressing, alternation and reset
   a_tx_fetch_addr: assert property (tx_issue
      |=> mem_req.addr == 13'($past(st_reg.start[tx_idx]) + $past(st_reg.tx_cnt)))
      else $error("transmit fetch outside the active buffer");

   a_tx_sel_flip: assert property (tx_issue && 13'(st_reg.start[tx_idx] + st_reg.tx_cnt)
      == st_reg.last[tx_idx] && !tx_reset_wr |=> st_reg.tx_sel != $past(st_reg.tx_sel))
      else $error("transmit buffer selection did not alternate at buffer end");

   a_tx_reset_zero: assert property (tx_reset_wr
      |=> st_reg.tx_cnt == 13'h0 && !tx_out_valid)
      else $error("transmit reset left offset or queue");

   a_tx_queue_order: assert property (st_reg.q_v[1] |-> st_reg.q_v[0])
      else $error("second queue entry valid with the head empty");

   // register port answers and buffer address writes
   a_rd_cnt_val: assert property (reg_rd && reg_addr == `SDBP_OFF_TX_ACTIVE
      |=> reg_rdata == {3'b000, $past(st_reg.tx_cnt)})
      else $error("transmit offset read back wrong");

   a_rd_idle_zero: assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data present without a read");

   a_cfg_a_write: assert property (reg_wr && reg_addr == `SDBP_OFF_RX_A_END
      |=> st_reg.last[0] == $past(reg_wdata[12:0]) && $stable(st_reg.last[1]))
      else $error("receive buffer a end not written independently");

   a_cfg_tx_a: assert property (reg_wr && reg_addr == `SDBP_OFF_TX_A_START
      |=> st_reg.start[2] == $past(reg_wdata[12:0]) && $stable(st_reg.start[3]))
      else $error("transmit buffer a start not written independently");

endmodule : sdbp_top

// ### dv/sdbp_ram_model.sv
// behavioural on-chip ram that stands on the far side of the serial dma block
// assumes one request per cycle on mem_req and read data expected one cycle later
`timescale 1ns/1ps
module sdbp_ram_model
   import sdbp_pkg::*;
(
   // clock
   input  wire logic             clk,
   // ram port
   input  wire sdbp_mem_req_type mem_req,
   output logic      [7:0]       mem_rdata
);
   logic [7:0] mem [0:8191];

   // preload a pattern the bench can recompute from the address
   initial begin
      for (int i = 0; i < 8192; i++) mem[i] = 8'(i) ^ 8'h5A;
      mem_rdata = 8'h00;
   end

   // writes land at once; read data stands one cycle, then the line toggles
   always @(posedge clk) begin
      if (mem_req.valid === 1'b1 && mem_req.we === 1'b1) mem[mem_req.addr] <= mem_req.data;
      if (mem_req.valid === 1'b1 && mem_req.we === 1'b0) begin
         mem_rdata <= mem[mem_req.addr];
      end else begin
         mem_rdata <= ~mem_rdata; // released data is not worth trusting
      end
   end
endmodule : sdbp_ram_model

// ### dv/tb_top.sv
// self-checking bench of the serial dma buffer pointer block
// assumes the ram model above and the offsets of sdbp_cfg.svh
`timescale 1ns/1ps
`include "sdbp_cfg.svh"
module tb_top
   import sdbp_pkg::*;
();
   logic             clk;
   logic             rstn;
   logic [15:0]      reg_addr;
   logic [15:0]      reg_wdata;
   logic             reg_wr;
   logic             reg_rd;
   logic [15:0]      reg_rdata;
   logic             rx_in_valid;
   sdbp_rx_byte_type rx_in;
   logic             rx_in_ready;
   logic             tx_out_valid;
   logic [7:0]       tx_out_data;
   logic             tx_out_ready;
   sdbp_mem_req_type mem_req;
   logic [7:0]       mem_rdata;
   int               err_count;
   int               checked;
   int               cycles;

   sdbp_top dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_in_valid(rx_in_valid),
      .rx_in(rx_in), .rx_in_ready(rx_in_ready), .tx_out_valid(tx_out_valid),
      .tx_out_data(tx_out_data), .tx_out_ready(tx_out_ready), .mem_req(mem_req),
      .mem_rdata(mem_rdata));
   sdbp_ram_model ram (.clk(clk), .mem_req(mem_req), .mem_rdata(mem_rdata));

   // 40 MHz clock
   always #12.5 clk = ~clk;

   // hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_count++;
         final_report();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask : reg_write

   // read data stands only in the cycle after the strobe
   task automatic reg_check(input logic [15:0] a, input logic [15:0] exp);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1;
      chk(reg_rdata, exp, $sformatf("reg %h", a));
   endtask : reg_check

   // offer one byte and hold it until an edge sees ready high
   task automatic send_rx(input logic [7:0] d, input logic ferr);
      int n;
      n = 0;
      @(posedge clk);
      rx_in_valid <= 1'b1;
      rx_in       <= '{data: d, frame_err: ferr};
      do begin
         @(posedge clk);
         n++;
      end while (rx_in_ready !== 1'b1 && n < 50);
      rx_in_valid <= 1'b0;
      rx_in       <= '{data: ~d, frame_err: ~ferr};
   endtask : send_rx

   // reset values, fixed top bits, independence, read-only and unmapped places
   task automatic test_regs();
      for (int i = 0; i < 8; i++) reg_check(16'h4480 + 16'(2 * i), 16'h6000);
      for (int i = 0; i < 8; i++) reg_write(16'h4480 + 16'(2 * i), 16'h9000 | 16'(i));
      for (int i = 0; i < 8; i++) reg_check(16'h4480 + 16'(2 * i), 16'h7000 | 16'(i));
      reg_write(`SDBP_OFF_TX_ACTIVE, 16'hFFFF);
      reg_check(`SDBP_OFF_TX_ACTIVE, 16'h0000);
      reg_check(`SDBP_OFF_RX_A_ERR, 16'h0000);
      reg_check(`SDBP_OFF_RX_B_ERR, 16'h0000);
      reg_check(16'h44FE, 16'h0000);
   endtask : test_regs

   // fill a then b with bad bytes, then reload a and capture again
   task automatic test_rx();
      reg_write(`SDBP_OFF_RX_A_START, 16'h0100);
      reg_write(`SDBP_OFF_RX_A_END, 16'h0103);
      reg_write(`SDBP_OFF_RX_B_START, 16'h0200);
      reg_write(`SDBP_OFF_RX_B_END, 16'h0201);
      reg_write(`SDBP_OFF_CONTROL, 16'h0003);
      send_rx(8'hC0, 1'b0);
      send_rx(8'hC1, 1'b0);
      reg_check(`SDBP_OFF_RX_A_NEXT, 16'h0002);
      send_rx(8'hC2, 1'b1);
      send_rx(8'hC3, 1'b1);
      send_rx(8'hD0, 1'b0);
      send_rx(8'hD1, 1'b1);
      reg_check(`SDBP_OFF_RX_A_ERR, 16'h0002);
      reg_check(`SDBP_OFF_RX_B_ERR, 16'h0001);
      reg_check(`SDBP_OFF_RX_A_NEXT, 16'h0000);
      reg_check(`SDBP_OFF_STATUS, 16'h00C0);
      for (int i = 0; i < 4; i++) chk(16'(ram.mem[13'h100 + i]), 16'h00C0 + 16'(i), "ram a");
      chk(16'(ram.mem[13'h201]), 16'h00D1, "ram b");
      reg_write(`SDBP_OFF_CONTROL, 16'h0001);
      reg_check(`SDBP_OFF_RX_A_ERR, 16'h0000);
      reg_check(`SDBP_OFF_STATUS, 16'h0081);
      send_rx(8'hE0, 1'b0);
      send_rx(8'hE1, 1'b1);
      reg_check(`SDBP_OFF_RX_A_ERR, 16'h0001);
   endtask : test_rx

   // stall the sink until the queue is full, then drain the buffer in order
   task automatic test_tx();
      int n;
      reg_write(`SDBP_OFF_TX_A_START, 16'h0300);
      reg_write(`SDBP_OFF_TX_A_END, 16'h0302);
      reg_write(`SDBP_OFF_CONTROL, 16'h0004);
      repeat (20) @(posedge clk);
      reg_check(`SDBP_OFF_TX_ACTIVE, 16'h0002);
      chk(16'(tx_out_valid), 16'h0001, "tx head valid");
      tx_out_ready <= 1'b1;
      n = 0;
      for (int k = 0; k < 40 && n < 3; k++) begin
         @(posedge clk);
         if (tx_out_valid === 1'b1) begin
            chk(16'(tx_out_data), 16'(8'(n) ^ 8'h5A), "tx byte");
            n++;
         end
      end
      tx_out_ready <= 1'b0;
      chk(16'(n), 16'h0003, "tx count");
      reg_check(`SDBP_OFF_TX_ACTIVE, 16'h0000);
   endtask : test_tx

   // second transmit buffer, transmit reset, then receive reset
   task automatic test_more();
      reg_write(`SDBP_OFF_TX_B_START, 16'h0405);
      reg_write(`SDBP_OFF_TX_B_END, 16'h0405);
      reg_write(`SDBP_OFF_CONTROL, 16'h0008);
      repeat (10) @(posedge clk);
      reg_check(`SDBP_OFF_TX_ACTIVE, 16'h0000);
      chk(16'(tx_out_valid), 16'h0001, "tx b valid");
      chk(16'(tx_out_data), 16'h005F, "tx b byte");
      tx_out_ready <= 1'b1;
      @(posedge clk);
      tx_out_ready <= 1'b0;
      reg_check(`SDBP_OFF_STATUS, 16'h00C1);
      chk(16'(tx_out_valid), 16'h0000, "tx b drained");
      reg_write(`SDBP_OFF_CONTROL, 16'h0004);
      repeat (12) @(posedge clk);
      reg_check(`SDBP_OFF_TX_ACTIVE, 16'h0002);
      reg_write(`SDBP_OFF_CONTROL, 16'h0020);
      reg_check(`SDBP_OFF_TX_ACTIVE, 16'h0000);
      chk(16'(tx_out_valid), 16'h0000, "tx reset queue");
      reg_check(`SDBP_OFF_RX_B_NEXT, 16'h0000);
      reg_check(`SDBP_OFF_RX_A_NEXT, 16'h0002);
      chk(16'(rx_in_ready), 16'h0001, "rx ready loaded");
      reg_write(`SDBP_OFF_CONTROL, 16'h0010);
      reg_check(`SDBP_OFF_STATUS, 16'h0000);
      chk(16'(rx_in_ready), 16'h0000, "rx reset ready");
      reg_check(`SDBP_OFF_RX_A_NEXT, 16'h0000);
      reg_check(`SDBP_OFF_RX_A_ERR, 16'h0000);
   endtask : test_more

   task automatic final_report();
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report

   // reset, then the scenarios in turn
   initial begin
      clk          = 1'b0;
      rstn         = 1'b0;
      reg_addr     = 16'h0000;
      reg_wdata    = 16'h0000;
      reg_wr       = 1'b0;
      reg_rd       = 1'b0;
      rx_in_valid  = 1'b0;
      rx_in        = '0;
      tx_out_ready = 1'b0;
      err_count    = 0;
      checked      = 0;
      cycles       = 0;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      test_regs();
      test_rx();
      test_tx();
      test_more();
      final_report();
   end
endmodule : tb_top
